/* core/pfm_map.vh */
// Address map, field positions, reset values and codes of the pin-function mux
`ifndef PFM_MAP_VH
`define PFM_MAP_VH

// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define PFM_A_CTRL 8'h00
`define PFM_A_PA_OUT 8'h04
`define PFM_A_PA_DIR 8'h08
`define PFM_A_PC_OUT 8'h0c
`define PFM_A_PC_DIR 8'h10
`define PFM_A_PD_OUT 8'h14
`define PFM_A_PD_DIR 8'h18
`define PFM_A_PB_OUT 8'h1c
`define PFM_A_STATUS 8'h20
`define PFM_A_PIN_IN 8'h24

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define PFM_C_PWM_EN 0
`define PFM_C_FLASH_EN 1
`define PFM_C_CORE_CLOCK_OUT_OUT 2
`define PFM_C_KEY_EN 3
`define PFM_C_I2C_EN 4
`define PFM_C_PANEL_LO 5
`define PFM_C_PANEL_HI 6
`define PFM_C_HOST_LO 7
`define PFM_C_HOST_HI 8
`define PFM_C_W 9
`define PFM_CTRL_RST 9'h020
`define PFM_PB_OUT_BIT 4

// ----------------------------------------------------------------
// Mode codes
// ----------------------------------------------------------------
`define PFM_PANEL_GPIO 2'h3
`define PFM_PANEL_16 2'h2
`define PFM_PANEL_18 2'h1
`define PFM_PANEL_24 2'h0
`define PFM_HOST_SERIAL 2'h0
`define PFM_HOST_PAR8 2'h1
`define PFM_HOST_PAR16 2'h2
`define PFM_FLASH_ISP 2'h1

// ----------------------------------------------------------------
// Port C bit slots inside the 8-bit port C field
// ----------------------------------------------------------------
`define PFM_PC_PWM_BIT 7
`define PFM_PORT_RST 8'h00

// ----------------------------------------------------------------
// Status and pin read-back fields
// ----------------------------------------------------------------
`define PFM_S_TEST_LO 0
`define PFM_S_INIT 3
`define PFM_S_PLL_OFF 4
`define PFM_S_ISP 5
`define PFM_S_KEY_ACT 6
`define PFM_P_PB_LO 24

// ----------------------------------------------------------------
// Reset qualification length in oscillator clocks
// ----------------------------------------------------------------
`define PFM_RST_LEN 256

`endif

/* core/pfm_rst_qual.v */
// Reset pin qualifier that ignores low pulses shorter than a set length
`timescale 1ns/1ps
`default_nettype none
`include "pfm_map.vh"

module pfm_rst_qual
#(
   parameter LEN = `PFM_RST_LEN,
   parameter CW = 9
)
(
   // Clock and power-on reset
   input wire clk,
   input wire rst_n,
   // Board reset pin, low active
   input wire reset_pin_n,
   // Qualified reset request
   output reg qual_reset_q
);

   reg [CW-1:0] count_q;

   // ----------------------------------------------------------------
   // Low-time counter
   // ----------------------------------------------------------------
   // Counts consecutive low samples; only a full-length run resets
   always @(posedge clk)
   begin
      if (!rst_n || reset_pin_n)
      begin
         count_q <= {CW{1'b0}};
         qual_reset_q <= 1'b0;
      end
      else if (count_q != LEN[CW-1:0] - {{(CW-1){1'b0}}, 1'b1})
      begin
         count_q <= count_q + {{(CW-1){1'b0}}, 1'b1};
      end
      else
      begin
         qual_reset_q <= 1'b1;
      end
   end

endmodule

`default_nettype wire

/* core/pfm_pin_mux.v */
// Pin-function multiplexer, strap capture and reset qualification with APB registers
`timescale 1ns/1ps
`default_nettype none
`include "pfm_map.vh"

module pfm_pin_mux
#(
   parameter RST_LEN = `PFM_RST_LEN
)
(
   // Clock and resets
   input wire clk,
   input wire rst_n,
   input wire reset_pin_n,
   output reg core_reset_n_q,
   // APB slave
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata_q,
   output reg pready_q,
   output reg pslverr_q,
   // Straps
   input wire [2:0] test_strap,
   output reg pll_disable_q,
   output reg initial_display_en_q,
   // Engine side
   input wire pwm0_level,
   input wire pwm1_level,
   input wire flash_master_sclk,
   input wire flash_master_out,
   input wire flash_select_0_n,
   input wire flash_select_1_n,
   output reg flash_master_in_q,
   input wire [7:0] host_db_hi_out,
   input wire host_db_hi_oe,
   input wire [4:0] key_scan_strobe,
   output reg [4:0] key_inputs_q,
   input wire i2c_scl_low,
   input wire i2c_sda_low,
   output reg i2c_scl_in_q,
   output reg i2c_sda_in_q,
   input wire [7:0] panel_shared_data,
   output reg ext_panel_clk_q,
   // First pulse pin, also initial-display strap
   input wire pwm0_pin_in,
   output reg pwm0_pin_out_q,
   output reg pwm0_pin_oe_q,
   output reg init_pulldown_en_q,
   // Second pulse pin
   input wire pwm1_pin_in,
   output reg pwm1_pin_out_q,
   output reg pwm1_pin_oe_q,
   // Flash pins {select1, select0, in, out, clock}
   input wire [4:0] flash_pin_in,
   output reg [4:0] flash_pin_out_q,
   output reg [4:0] flash_pin_oe_q,
   // Upper host data bus pins
   input wire [7:0] host_data_bus_in,
   output reg [7:0] host_data_bus_out_q,
   output reg [7:0] host_data_bus_oe_q,
   // Host control pins as port B inputs
   input wire [3:0] port_b_inputs,
   // Key input zero and key strobe zero pins
   input wire key_in0_pin_in,
   output reg key_in0_pin_out_q,
   output reg key_in0_pin_oe_q,
   input wire key_strobe0_pin_in,
   output reg key_strobe0_pin_out_q,
   output reg key_strobe0_pin_oe_q,
   output reg [4:0] key_pullup_en_q,
   // Shared panel pins in port D bit order
   input wire [7:0] port_d_pins_in,
   output reg [7:0] port_d_pins_out_q,
   output reg [7:0] port_d_pins_oe_q
);

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   wire qual_reset;
   wire in_reset;
   reg [`PFM_C_W-1:0] ctrl_q;
   reg [7:0] pa_out_q;
   reg [7:0] pa_dir_q;
   reg [7:0] pc_out_q;
   reg [7:0] pc_dir_q;
   reg [7:0] pd_out_q;
   reg [7:0] pd_dir_q;
   reg pb_out_q;
   reg [3:0] strap_s1_q;
   reg [3:0] strap_s2_q;
   reg [3:0] strap_q;
   reg core_clock_out_q;
   reg [31:0] rd_d;
   reg err_d;
   reg [1:0] panel;
   reg [1:0] host;
   reg pwm_en;
   reg flash_en;
   reg key_act;
   reg i2c_en;
   reg isp;
   reg pa_ok;
   reg pc_ok;
   reg [7:0] pd_ok;
   reg [7:0] key_d_pin;
   reg [7:0] key_d_drive;
   reg pwm0_out_d;
   reg pwm0_oe_d;
   reg pwm1_out_d;
   reg pwm1_oe_d;
   reg [4:0] fl_out_d;
   reg [4:0] fl_oe_d;
   reg [7:0] pd_out_d;
   reg [7:0] pd_oe_d;
   reg ks0_oe_d;
   reg ki0_oe_d;
   integer i;

   // Open-drain enable for a driver that wants the pin low
   function od_en;
      input want_low;
      begin
         od_en = want_low;
      end
   endfunction

   // ----------------------------------------------------------------
   // Reset qualification
   // ----------------------------------------------------------------
   pfm_rst_qual #(.LEN(RST_LEN), .CW(9)) u_rst_qual
   (
      .clk(clk),
      .rst_n(rst_n),
      .reset_pin_n(reset_pin_n),
      .qual_reset_q(qual_reset)
   );

   // Software registers held while either reset source is active; pin registers reset on rst_n only
   assign in_reset = !rst_n || qual_reset;

   // ----------------------------------------------------------------
   // Strap capture
   // ----------------------------------------------------------------
   // Two-stage synchroniser, then sample frozen at reset release
   always @(posedge clk)
   begin
      strap_s1_q <= {pwm0_pin_in, test_strap};
      strap_s2_q <= strap_s1_q;
      if (in_reset)
      begin
         strap_q <= strap_s2_q;
      end
   end

   // ----------------------------------------------------------------
   // Mode decode
   // ----------------------------------------------------------------
   // Shared-pin ownership from control fields and straps
   always @*
   begin
      panel = ctrl_q[`PFM_C_PANEL_HI:`PFM_C_PANEL_LO];
      host = ctrl_q[`PFM_C_HOST_HI:`PFM_C_HOST_LO];
      pwm_en = ctrl_q[`PFM_C_PWM_EN];
      flash_en = ctrl_q[`PFM_C_FLASH_EN];
      i2c_en = ctrl_q[`PFM_C_I2C_EN];
      isp = (strap_q[2:1] == `PFM_FLASH_ISP);
      key_act = ctrl_q[`PFM_C_KEY_EN] && (panel != `PFM_PANEL_24);
      pa_ok = (host == `PFM_HOST_SERIAL) || (host == `PFM_HOST_PAR8);
      pc_ok = !pwm_en && !flash_en;
      // Low six bits in 16/18 bit and GPIO, top two only in 16 bit and GPIO
      pd_ok[5:0] = (panel != `PFM_PANEL_24) ? 6'h3f : 6'h00;
      pd_ok[7:6] = (panel == `PFM_PANEL_16 || panel == `PFM_PANEL_GPIO) ? 2'h3 : 2'h0;
   end

   // ----------------------------------------------------------------
   // Key and panel sharing on port D order
   // ----------------------------------------------------------------
   // Key inputs 1..4 on D0, D1, D2, D6; strobes 1..4 on D4, D5, D3, D7
   always @*
   begin
      key_d_pin = 8'h47;
      key_d_drive = 8'h00;
      key_d_drive[4] = od_en(!key_scan_strobe[1]);
      key_d_drive[5] = od_en(!key_scan_strobe[2]);
      key_d_drive[3] = od_en(!key_scan_strobe[3]);
      key_d_drive[7] = od_en(!key_scan_strobe[4]);
      for (i = 0; i < 8; i = i + 1)
      begin
         if (panel == `PFM_PANEL_24)
         begin
            pd_out_d[i] = panel_shared_data[i];
            pd_oe_d[i] = 1'b1;
         end
         else if (key_act)
         begin
            // Input pins float; strobe pins only pull low
            pd_out_d[i] = 1'b0;
            pd_oe_d[i] = key_d_pin[i] ? 1'b0 : key_d_drive[i];
         end
         else if (pd_ok[i])
         begin
            pd_out_d[i] = pd_out_q[i];
            pd_oe_d[i] = pd_dir_q[i];
         end
         else
         begin
            pd_out_d[i] = panel_shared_data[i];
            pd_oe_d[i] = 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // Pulse, flash and key-zero pins
   // ----------------------------------------------------------------
   always @*
   begin
      // First pulse pin: pulse output, else port C7 or core clock
      if (in_reset)
      begin
         pwm0_out_d = 1'b0;
         pwm0_oe_d = 1'b0;
      end
      else if (pwm_en)
      begin
         pwm0_out_d = pwm0_level;
         pwm0_oe_d = 1'b1;
      end
      else if (ctrl_q[`PFM_C_CORE_CLOCK_OUT_OUT])
      begin
         pwm0_out_d = core_clock_out_q;
         pwm0_oe_d = 1'b1;
      end
      else
      begin
         pwm0_out_d = pc_out_q[`PFM_PC_PWM_BIT];
         pwm0_oe_d = pc_ok && pc_dir_q[`PFM_PC_PWM_BIT];
      end
      // Second pulse pin becomes a clock input under test bit 0
      pwm1_out_d = pwm1_level;
      pwm1_oe_d = pwm_en && !strap_q[0];
      // Flash pins: float for programming, engine, or port C
      if (isp)
      begin
         fl_out_d = 5'h00;
         fl_oe_d = 5'h00;
      end
      else if (flash_en)
      begin
         fl_out_d = {flash_select_1_n, flash_select_0_n, 1'b0, flash_master_out,
            flash_master_sclk};
         fl_oe_d = 5'h1b;
      end
      else
      begin
         fl_out_d = pc_out_q[4:0];
         fl_oe_d = pc_ok ? pc_dir_q[4:0] : 5'h00;
      end
      // Key pins zero: I2C lines, else key strobe or port B bit 4
      if (i2c_en)
      begin
         ki0_oe_d = od_en(i2c_scl_low);
         ks0_oe_d = od_en(i2c_sda_low);
      end
      else if (key_act)
      begin
         ki0_oe_d = 1'b0;
         ks0_oe_d = od_en(!key_scan_strobe[0]);
      end
      else
      begin
         ki0_oe_d = 1'b0;
         ks0_oe_d = od_en(!pb_out_q);
      end
   end

   // ----------------------------------------------------------------
   // Register read mux
   // ----------------------------------------------------------------
   always @*
   begin
      rd_d = 32'h0000_0000;
      err_d = 1'b0;
      if (paddr == `PFM_A_CTRL)
         rd_d[`PFM_C_W-1:0] = ctrl_q;
      else if (paddr == `PFM_A_PA_OUT)
         rd_d[7:0] = pa_out_q;
      else if (paddr == `PFM_A_PA_DIR)
         rd_d[7:0] = pa_dir_q;
      else if (paddr == `PFM_A_PC_OUT)
         rd_d[7:0] = pc_out_q;
      else if (paddr == `PFM_A_PC_DIR)
         rd_d[7:0] = pc_dir_q;
      else if (paddr == `PFM_A_PD_OUT)
         rd_d[7:0] = pd_out_q;
      else if (paddr == `PFM_A_PD_DIR)
         rd_d[7:0] = pd_dir_q;
      else if (paddr == `PFM_A_PB_OUT)
         rd_d[`PFM_PB_OUT_BIT] = pb_out_q;
      else if (paddr == `PFM_A_STATUS)
      begin
         rd_d[`PFM_S_TEST_LO+2:`PFM_S_TEST_LO] = strap_q[2:0];
         rd_d[`PFM_S_INIT] = strap_q[3];
         rd_d[`PFM_S_PLL_OFF] = strap_q[0];
         rd_d[`PFM_S_ISP] = isp;
         rd_d[`PFM_S_KEY_ACT] = key_act;
      end
      else if (paddr == `PFM_A_PIN_IN)
      begin
         rd_d[7:0] = pa_ok ? host_data_bus_in : 8'h00;
         rd_d[15:8] = {pwm0_pin_in, 2'h0, flash_pin_in};
         rd_d[23:16] = port_d_pins_in;
         // Host control pins read back only in serial host mode
         if (host == `PFM_HOST_SERIAL)
            rd_d[`PFM_P_PB_LO+3:`PFM_P_PB_LO] = port_b_inputs;
         rd_d[`PFM_P_PB_LO+4] = key_in0_pin_in;
      end
      else
         err_d = 1'b1;
   end

   // ----------------------------------------------------------------
   // APB slave and software registers
   // ----------------------------------------------------------------
   // One wait-free access cycle: data loaded at setup, write at access
   always @(posedge clk)
   begin
      if (in_reset)
      begin
         ctrl_q <= `PFM_CTRL_RST;
         pa_out_q <= `PFM_PORT_RST;
         pa_dir_q <= `PFM_PORT_RST;
         pc_out_q <= `PFM_PORT_RST;
         pc_dir_q <= `PFM_PORT_RST;
         pd_out_q <= `PFM_PORT_RST;
         pd_dir_q <= `PFM_PORT_RST;
         pb_out_q <= 1'b1;
         prdata_q <= 32'h0000_0000;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
      end
      else
      begin
         pready_q <= psel && !penable;
         if (psel && !penable)
         begin
            prdata_q <= pwrite ? 32'h0000_0000 : rd_d;
            pslverr_q <= err_d;
         end
         if (psel && penable && pready_q && pwrite)
         begin
            if (paddr == `PFM_A_CTRL)
               ctrl_q <= pwdata[`PFM_C_W-1:0];
            else if (paddr == `PFM_A_PA_OUT)
               pa_out_q <= pwdata[7:0];
            else if (paddr == `PFM_A_PA_DIR)
               pa_dir_q <= pwdata[7:0];
            else if (paddr == `PFM_A_PC_OUT)
               pc_out_q <= pwdata[7:0];
            else if (paddr == `PFM_A_PC_DIR)
               pc_dir_q <= pwdata[7:0];
            else if (paddr == `PFM_A_PD_OUT)
               pd_out_q <= pwdata[7:0];
            else if (paddr == `PFM_A_PD_DIR)
               pd_dir_q <= pwdata[7:0];
            else if (paddr == `PFM_A_PB_OUT)
               pb_out_q <= pwdata[`PFM_PB_OUT_BIT];
         end
      end
   end

   // ----------------------------------------------------------------
   // Pin output registers
   // ----------------------------------------------------------------
   always @(posedge clk)
   begin
      if (!rst_n)
      begin
         core_clock_out_q <= 1'b0;
         core_reset_n_q <= 1'b0;
         pll_disable_q <= 1'b0;
         initial_display_en_q <= 1'b0;
         init_pulldown_en_q <= 1'b1;
         pwm0_pin_out_q <= 1'b0;
         pwm0_pin_oe_q <= 1'b0;
         pwm1_pin_out_q <= 1'b0;
         pwm1_pin_oe_q <= 1'b0;
         ext_panel_clk_q <= 1'b0;
         flash_pin_out_q <= 5'h00;
         flash_pin_oe_q <= 5'h00;
         flash_master_in_q <= 1'b0;
         host_data_bus_out_q <= 8'h00;
         host_data_bus_oe_q <= 8'h00;
         key_in0_pin_out_q <= 1'b0;
         key_in0_pin_oe_q <= 1'b0;
         key_strobe0_pin_out_q <= 1'b0;
         key_strobe0_pin_oe_q <= 1'b0;
         key_pullup_en_q <= 5'h1f;
         key_inputs_q <= 5'h1f;
         i2c_scl_in_q <= 1'b1;
         i2c_sda_in_q <= 1'b1;
         port_d_pins_out_q <= 8'h00;
         port_d_pins_oe_q <= 8'h00;
      end
      else
      begin
         core_clock_out_q <= !core_clock_out_q;
         core_reset_n_q <= !in_reset;
         pll_disable_q <= strap_q[0];
         initial_display_en_q <= strap_q[3] && !in_reset;
         init_pulldown_en_q <= in_reset;
         pwm0_pin_out_q <= pwm0_out_d;
         pwm0_pin_oe_q <= pwm0_oe_d;
         pwm1_pin_out_q <= pwm1_out_d;
         pwm1_pin_oe_q <= pwm1_oe_d;
         ext_panel_clk_q <= strap_q[0] && pwm1_pin_in;
         flash_pin_out_q <= fl_out_d;
         flash_pin_oe_q <= fl_oe_d;
         flash_master_in_q <= flash_pin_in[2];
         // Upper host data: port A where free, host engine otherwise
         host_data_bus_out_q <= pa_ok ? pa_out_q : host_db_hi_out;
         host_data_bus_oe_q <= pa_ok ? pa_dir_q : {8{host_db_hi_oe}};
         key_in0_pin_out_q <= 1'b0;
         key_in0_pin_oe_q <= ki0_oe_d;
         key_strobe0_pin_out_q <= 1'b0;
         key_strobe0_pin_oe_q <= ks0_oe_d;
         key_pullup_en_q <= 5'h1f;
         // Key inputs read idle high when the matrix is off
         key_inputs_q <= key_act ? {port_d_pins_in[6], port_d_pins_in[2:0], key_in0_pin_in}
            : 5'h1f;
         i2c_scl_in_q <= key_in0_pin_in;
         i2c_sda_in_q <= key_strobe0_pin_in;
         port_d_pins_out_q <= pd_out_d;
         port_d_pins_oe_q <= pd_oe_d;
      end
   end

endmodule

`default_nettype wire

/* test/pfm_pin_mux_assertions.sv */
// Concurrent checks on the pin-function mux ports
`timescale 1ns/1ps
`default_nettype none
module pfm_pin_mux_chk
#(
   parameter RST_LEN = 256
)
(
   // Clock and resets
   input wire clk,
   input wire rst_n,
   input wire reset_pin_n,
   input wire core_reset_n_q,
   // Strap results and pins
   input wire pll_disable_q,
   input wire initial_display_en_q,
   input wire init_pulldown_en_q,
   input wire ext_panel_clk_q,
   input wire pwm1_pin_in,
   input wire pwm1_pin_oe_q,
   input wire [4:0] key_pullup_en_q,
   input wire key_strobe0_pin_out_q,
   input wire key_in0_pin_in,
   input wire i2c_scl_in_q
);
   // ----
   // Helpers
   // ----
   reg [1:0] up_q;
   reg [9:0] low_q;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   // Edges since reset release, saturating at three
   always @(posedge clk)
   begin
      if (!rst_n)
         up_q <= 2'h0;
      else if (up_q != 2'h3)
         up_q <= up_q + 2'h1;
   end

   // Consecutive low samples of the board reset pin
   always @(posedge clk)
   begin
      if (!rst_n || reset_pin_n)
         low_q <= 10'h0;
      else if (low_q != RST_LEN)
         low_q <= low_q + 10'h1;
   end

   property p_pullup; key_pullup_en_q == 5'h1f; endproperty
   a_pullup: assert property (p_pullup) else $error("key pull-ups off");
   property p_pdoff; up_q == 2'h3 && core_reset_n_q |-> !init_pulldown_en_q; endproperty
   a_pdoff: assert property (p_pdoff) else $error("pull-down after reset");
   property p_frozen;
      core_reset_n_q && $past(core_reset_n_q) |-> $stable({pll_disable_q, initial_display_en_q});
   endproperty
   a_frozen: assert property (p_frozen) else $error("strap moved");
   property p_extoff; up_q == 2'h3 && !pll_disable_q |-> !ext_panel_clk_q; endproperty
   a_extoff: assert property (p_extoff) else $error("external clock used");
   property p_exton;
      up_q == 2'h3 && pll_disable_q |-> ext_panel_clk_q == $past(pwm1_pin_in) && !pwm1_pin_oe_q;
   endproperty
   a_exton: assert property (p_exton) else $error("pin two not clock input");
   property p_od0; key_strobe0_pin_out_q == 1'b0; endproperty
   a_od0: assert property (p_od0) else $error("strobe zero driven high");
   property p_scl; up_q != 2'h0 |-> i2c_scl_in_q == $past(key_in0_pin_in); endproperty
   a_scl: assert property (p_scl) else $error("clock line not sampled");
   property p_qual; low_q == RST_LEN |-> ##[1:3] !core_reset_n_q; endproperty
   a_qual: assert property (p_qual) else $error("long reset ignored");
   property p_short; low_q < RST_LEN - 1 && core_reset_n_q |=> core_reset_n_q; endproperty
   a_short: assert property (p_short) else $error("short pulse reset");
endmodule

bind pfm_pin_mux pfm_pin_mux_chk #(.RST_LEN(RST_LEN)) chk_i (.*);
`default_nettype wire

/* test/pfm_board.sv */
// Board model: strap resistor, open-drain pull-ups and external panel clock
`timescale 1ns/1ps
`default_nettype none
module pfm_board
(
   // Bench settings
   input wire logic clk,
   input wire logic strap_hi,
   input wire logic key0_ext,
   // Device drive on shared pins
   input wire logic pwm0_out,
   input wire logic pwm0_oe,
   input wire logic ki0_out,
   input wire logic ki0_oe,
   input wire logic ko0_out,
   input wire logic ko0_oe,
   // Pin levels seen by the device
   output logic pwm0_lvl,
   output logic pwm1_lvl,
   output logic ki0_lvl,
   output logic ko0_lvl
);
   // Strap resistor sets the pin whenever the device leaves it
   assign pwm0_lvl = pwm0_oe ? pwm0_out : strap_hi;
   // Open-drain lines with pull-ups; the key may hold line zero low
   assign ki0_lvl = (ki0_oe && !ki0_out) ? 1'b0 : key0_ext;
   assign ko0_lvl = (ko0_oe && !ko0_out) ? 1'b0 : 1'b1;
   // Free-running external panel clock at half the core rate
   always @(posedge clk)
      pwm1_lvl <= (pwm1_lvl === 1'b1) ? 1'b0 : 1'b1;
endmodule
`default_nettype wire

/* test/pfm_pin_mux_tb.sv */
// Self-checking bench for the pin-function mux
`timescale 1ns/1ps
`default_nettype none
`include "pfm_map.vh"
module pfm_pin_mux_tb;
   // ----
   // Signals
   // ----
   logic clk, rst_n, reset_pin_n, psel, penable, pwrite, pready_q, pslverr_q, er;
   logic [7:0] paddr, host_db_hi_out, panel_shared_data, host_data_bus_in, port_d_pins_in;
   logic [31:0] pwdata, prdata_q, rd;
   logic [2:0] test_strap;
   logic [3:0] port_b_inputs;
   logic [4:0] key_scan_strobe, flash_pin_in, key_inputs_q, flash_pin_out_q, flash_pin_oe_q;
   logic [4:0] key_pullup_en_q;
   logic [7:0] host_data_bus_out_q, host_data_bus_oe_q, port_d_pins_out_q, port_d_pins_oe_q;
   logic pwm0_level, pwm1_level, flash_master_sclk, flash_master_out, flash_select_0_n;
   logic flash_select_1_n, host_db_hi_oe, i2c_scl_low, i2c_sda_low, pwm0_pin_in, pwm1_pin_in;
   logic key_in0_pin_in, key_strobe0_pin_in, core_reset_n_q, pll_disable_q;
   logic initial_display_en_q, flash_master_in_q, i2c_scl_in_q, i2c_sda_in_q;
   logic ext_panel_clk_q, pwm0_pin_out_q, pwm0_pin_oe_q, init_pulldown_en_q, pwm1_pin_out_q;
   logic pwm1_pin_oe_q, key_in0_pin_out_q, key_in0_pin_oe_q, key_strobe0_pin_out_q;
   logic key_strobe0_pin_oe_q, strap_hi, key0_ext;
   int mismatches, n_checks, cyc;
   localparam int LEN = 8;

   // Device with a short reset qualification
   pfm_pin_mux #(.RST_LEN(LEN)) uut (.*);
   // Board around the shared pins
   pfm_board brd (.clk(clk), .strap_hi(strap_hi), .key0_ext(key0_ext),
      .pwm0_out(pwm0_pin_out_q), .pwm0_oe(pwm0_pin_oe_q), .ki0_out(key_in0_pin_out_q),
      .ki0_oe(key_in0_pin_oe_q), .ko0_out(key_strobe0_pin_out_q),
      .ko0_oe(key_strobe0_pin_oe_q), .pwm0_lvl(pwm0_pin_in), .pwm1_lvl(pwm1_pin_in),
      .ki0_lvl(key_in0_pin_in), .ko0_lvl(key_strobe0_pin_in));

   // Clock
   initial
   begin
      clk = 0;
      forever #10 clk = ~clk;
   end

   // Hang guard
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         mismatches++;
         summarize();
      end
   end

   // ----
   // Tasks
   // ----
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         mismatches++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // One APB transfer, waiting for the slave's ready
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      tick(1);
      penable <= 1;
      do
      begin
         tick(1);
      end
      while (pready_q !== 1'b1);
      rd = prdata_q;
      er = pslverr_q;
      psel <= 0;
      penable <= 0;
      tick(1);
   endtask

   task automatic reboot(input logic s, input logic [2:0] t);
      rst_n <= 0;
      strap_hi <= s;
      test_strap <= t;
      tick(5);
      rst_n <= 1;
      tick(3);
   endtask

   task automatic s_regs;
      apb(0, `PFM_A_CTRL, 0);
      chk(rd, `PFM_CTRL_RST);
      apb(1, `PFM_A_PD_OUT, 32'h1a5);
      apb(0, `PFM_A_PD_OUT, 0);
      chk(rd, 32'ha5);
      apb(0, 8'h28, 0);
      chk({er, rd[30:0]}, 32'h80000000);
   endtask

   task automatic s_straps;
      chk({initial_display_en_q, pll_disable_q, init_pulldown_en_q}, 3'b110);
      test_strap <= 3'b000;
      apb(1, `PFM_A_CTRL, 32'h23);
      tick(2);
      chk({flash_pin_oe_q, pwm1_pin_oe_q, pll_disable_q}, 7'h01);
      apb(0, `PFM_A_STATUS, 0);
      chk({flash_master_in_q, rd[30:0]}, 32'h8000003b);
      reboot(0, 3'b000);
      chk({initial_display_en_q, pll_disable_q}, 2'b00);
      {flash_select_1_n, flash_select_0_n, flash_master_out, flash_master_sclk} <= 4'ha;
      pwm1_level <= 1;
      apb(1, `PFM_A_CTRL, 32'h23);
      tick(2);
      chk({flash_pin_oe_q, flash_pin_out_q, pwm1_pin_oe_q, pwm1_pin_out_q}, 12'hdcb);
   endtask

   task automatic s_pwm;
      apb(1, `PFM_A_PC_DIR, 32'h9f);
      apb(1, `PFM_A_PC_OUT, 32'h95);
      apb(1, `PFM_A_CTRL, 32'h21);
      pwm0_level <= 1;
      tick(2);
      chk({pwm0_pin_oe_q, pwm0_pin_out_q, flash_pin_oe_q}, 7'h60);
      pwm0_level <= 0;
      tick(2);
      chk({pwm0_pin_oe_q, pwm0_pin_out_q}, 2'b10);
      apb(1, `PFM_A_CTRL, 32'h20);
      tick(2);
      chk({pwm0_pin_oe_q, pwm0_pin_out_q, flash_pin_oe_q, flash_pin_out_q}, 12'hff5);
      apb(1, `PFM_A_PC_DIR, 32'h1f);
      tick(2);
      chk(pwm0_pin_oe_q, 1'b0);
      apb(1, `PFM_A_CTRL, 32'h24);
      tick(2);
      er = pwm0_pin_out_q;
      tick(1);
      chk({pwm0_pin_oe_q, pwm0_pin_out_q}, {1'b1, ~er});
   endtask

   task automatic s_portd;
      logic [7:0] e [4];
      e = '{8'h5a, 8'h65, 8'ha5, 8'ha5};
      apb(1, `PFM_A_PD_DIR, 32'hff);
      apb(1, `PFM_A_PD_OUT, 32'ha5);
      panel_shared_data <= 8'h5a;
      for (int m = 0; m < 4; m++)
      begin
         apb(1, `PFM_A_CTRL, 32'(m) << 5);
         tick(2);
         chk(port_d_pins_out_q, e[m]);
      end
   endtask

   task automatic s_keys;
      port_d_pins_in <= 8'h45;
      key0_ext <= 0;
      key_scan_strobe <= 5'h1c;
      apb(1, `PFM_A_CTRL, 32'h28);
      tick(2);
      chk({key_inputs_q, key_strobe0_pin_oe_q, port_d_pins_oe_q}, 14'h3510);
      apb(1, `PFM_A_CTRL, 32'h08);
      tick(2);
      chk(key_inputs_q, 5'h1f);
      key0_ext <= 1;
      apb(1, `PFM_A_CTRL, 32'h20);
      apb(1, `PFM_A_PB_OUT, 0);
      apb(0, `PFM_A_PIN_IN, 0);
      chk({key_strobe0_pin_oe_q, rd[28]}, 2'b11);
      apb(1, `PFM_A_CTRL, 32'h30);
      {i2c_scl_low, i2c_sda_low} <= 2'b11;
      tick(3);
      chk({key_in0_pin_oe_q, key_strobe0_pin_oe_q, i2c_sda_in_q}, 3'b110);
      {i2c_scl_low, i2c_sda_low} <= 2'b00;
      tick(3);
      chk({key_in0_pin_oe_q, key_strobe0_pin_oe_q, i2c_sda_in_q}, 3'b001);
   endtask

   task automatic s_host;
      apb(1, `PFM_A_PA_DIR, 32'hff);
      apb(1, `PFM_A_PA_OUT, 32'h3c);
      port_b_inputs <= 4'ha;
      host_db_hi_out <= 8'h96;
      host_db_hi_oe <= 1;
      apb(1, `PFM_A_CTRL, 32'h0a0);
      apb(0, `PFM_A_PIN_IN, 0);
      chk({host_data_bus_oe_q, host_data_bus_out_q, rd[27:24]}, 20'hff3c0);
      apb(1, `PFM_A_CTRL, 32'h120);
      tick(2);
      chk({host_data_bus_oe_q, host_data_bus_out_q}, 16'hff96);
      apb(1, `PFM_A_CTRL, 32'h020);
      apb(0, `PFM_A_PIN_IN, 0);
      chk({host_data_bus_oe_q, host_data_bus_out_q, rd[27:24]}, 20'hff3ca);
   endtask

   task automatic s_rstpin;
      reset_pin_n <= 0;
      tick(LEN - 1);
      reset_pin_n <= 1;
      tick(3);
      chk(core_reset_n_q, 1'b1);
      reset_pin_n <= 0;
      tick(LEN);
      reset_pin_n <= 1;
      tick(2);
      chk(core_reset_n_q, 1'b0);
      tick(3);
      apb(0, `PFM_A_PD_OUT, 0);
      chk(rd, 32'h0);
   endtask

   task automatic summarize;
      $display("mismatches=%0d n_checks=%0d", mismatches, n_checks);
      if (mismatches == 0 && n_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // Main sequence
   initial
   begin
      {psel, penable, pwrite, paddr, pwdata, pwm0_level, pwm1_level, host_db_hi_oe} = '0;
      {flash_master_sclk, flash_master_out, flash_select_0_n, flash_select_1_n} = '0;
      {host_db_hi_out, panel_shared_data, host_data_bus_in, port_d_pins_in} = '0;
      {i2c_scl_low, i2c_sda_low, port_b_inputs, rst_n} = '0;
      flash_pin_in = 5'h04;
      reset_pin_n = 1;
      key_scan_strobe = 5'h1f;
      strap_hi = 1;
      key0_ext = 1;
      test_strap = 3'b011;
      tick(5);
      rst_n <= 1;
      tick(3);
      s_regs();
      s_straps();
      s_pwm();
      s_portd();
      s_keys();
      s_host();
      s_rstpin();
      summarize();
   end
endmodule
`default_nettype wire
